// [hdl/dhbp_pkg.sv]
// Package: constants for the doubleword host bus port
package dhbp_pkg;
  // Word-order setting that selects swapped halves
  localparam logic [31:0] DHBP_SWAP_VALUE = 32'hFFFFFFFF;
  localparam logic [31:0] DHBP_SWAP_RESET = 32'h00000000;
  localparam int          DHBP_HALF_W     = 16;
  localparam int          DHBP_WORD_W     = 32;
  localparam int          DHBP_ADDR_W     = 8;
  localparam int          DHBP_BUF_DEPTH  = 2;
  localparam logic [1:0]  DHBP_HALF_NONE  = 2'h0;
endpackage

// [hdl/dhbp_skid_buf.sv]
// Two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dhbp_skid_buf #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  // Fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  if (DEPTH != 2 || WIDTH < 1) begin : g_bad_shape
    $error("dhbp_skid_buf: DEPTH must be 2 and WIDTH positive");
  end

  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic                  rd;
    logic                  wr;
    logic [1:0]            cnt;
  } dhbp_buf_t;

  dhbp_buf_t s_q, s_d;
  logic push, pop;

  assign in_ready_out  = (s_q.cnt != 2'h2);
  assign out_valid_out = (s_q.cnt != 2'h0);
  assign out_data_out  = s_q.mem[s_q.rd];
  assign push = in_valid_in && in_ready_out;
  assign pop  = out_valid_out && out_ready_in;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr] = in_data_in;
      s_d.wr = ~s_q.wr;
    end
    if (pop) begin
      s_d.rd = ~s_q.rd;
    end
    s_d.cnt = 2'(s_q.cnt + {1'b0, push} - {1'b0, pop});
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

// [hdl/dhbp_port.sv]
// Top: 16-bit host port assembling and splitting 32-bit doublewords
`timescale 1ns/1ps
`default_nettype none
module dhbp_port
  import dhbp_pkg::*;
#(
  parameter int ADDR_W = DHBP_ADDR_W
) (
  // Clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   resetn_in,
  // Word-order setting
  input  wire logic [DHBP_WORD_W-1:0] word_order_in,
  // Host strobes
  input  wire logic                   host_wr_in,
  input  wire logic                   host_rd_in,
  input  wire logic [ADDR_W-1:0]      host_addr_in,
  input  wire logic                   half_select_line_in,
  input  wire logic [DHBP_HALF_W-1:0] host_wdata_in,
  output logic [DHBP_HALF_W-1:0]      host_rdata_out,
  output logic                        host_rvalid_out,
  output logic                        host_rd_bad_out,
  output logic                        host_wr_stall_out,
  // Internal write side (through buffer)
  output logic                        int_wr_valid_out,
  input  wire logic                   int_wr_ready_in,
  output logic [ADDR_W-1:0]           int_wr_addr_out,
  output logic [DHBP_WORD_W-1:0]      int_wr_data_out,
  // Internal read side
  output logic                        int_rd_req_out,
  output logic [ADDR_W-1:0]           int_rd_addr_out,
  input  wire logic [DHBP_WORD_W-1:0] int_rd_data_in,
  // Network-order view of the last committed word
  output logic [DHBP_HALF_W-1:0]      net_first_half_out,
  output logic [DHBP_HALF_W-1:0]      net_second_half_out
);
  // ****************************************
  // Elaboration checks
  // ****************************************
  // The commit word carries the address beside the data
  if (ADDR_W < 1) begin : g_bad_addr_w
    $error("dhbp_port: ADDR_W must be positive");
  end
  // Two halves must tile one doubleword exactly
  if (DHBP_WORD_W != 2 * DHBP_HALF_W) begin : g_bad_split
    $error("dhbp_port: word must be two halves");
  end

  // ****************************************
  // State
  // ****************************************
  // Pair tracking for each direction plus the registered outputs
  typedef struct packed {
    logic                   wr_pend;
    logic                   wr_hi;
    logic [DHBP_HALF_W-1:0] wr_stage;
    logic                   rd_pend;
    logic                   rd_hi;
    logic [DHBP_WORD_W-1:0] rd_snap;
    logic [DHBP_HALF_W-1:0] rdata;
    logic                   rvalid;
    logic                   rbad;
    logic [DHBP_WORD_W-1:0] last;
  } dhbp_state_t;

  dhbp_state_t s_q, s_d;

  // Commit buffer handshake and payload
  logic                          buf_in_valid;
  logic                          buf_in_ready;
  logic [ADDR_W+DHBP_WORD_W-1:0] buf_in_data;
  logic [ADDR_W+DHBP_WORD_W-1:0] buf_out_data;
  // Decoded host strobes
  logic                          swap;
  logic                          bus_hi;
  logic                          wr_ok;
  logic                          wr_first;
  logic                          wr_same;
  logic                          wr_pair;
  logic [DHBP_WORD_W-1:0]        wr_word;
  logic                          rd_first;
  logic                          rd_same;
  logic                          rd_pair;

  // ****************************************
  // Helpers
  // ****************************************
  // Bus half to internal half; true selects bytes 3:2
  function automatic logic map_half(input logic sel, input logic sw);
    return sel ^ sw;
  endfunction

  // One internal half of a doubleword; hi picks bytes 3:2
  function automatic logic [DHBP_HALF_W-1:0] pick_half(input logic [DHBP_WORD_W-1:0] word,
                                                       input logic                   hi);
    return hi ? word[DHBP_WORD_W-1:DHBP_HALF_W] : word[DHBP_HALF_W-1:0];
  endfunction

  // Newest half placed by its internal position, staged half in the other
  function automatic logic [DHBP_WORD_W-1:0] join_halves(input logic [DHBP_HALF_W-1:0] now,
                                                         input logic [DHBP_HALF_W-1:0] held,
                                                         input logic                   hi);
    return hi ? {now, held} : {held, now};
  endfunction

  // ****************************************
  // Strobe decode
  // ****************************************
  assign swap   = (word_order_in == DHBP_SWAP_VALUE);
  assign bus_hi = map_half(half_select_line_in, swap);

  // Stall the host while buffer is full so no word is lost
  assign host_wr_stall_out = !buf_in_ready;
  assign wr_ok    = host_wr_in && buf_in_ready;
  assign wr_first = wr_ok && !s_q.wr_pend;
  // Pairing compares internal halves, so either order assembles
  assign wr_same  = wr_ok && s_q.wr_pend && (s_q.wr_hi == bus_hi);
  assign wr_pair  = wr_ok && s_q.wr_pend && (s_q.wr_hi != bus_hi);
  assign wr_word  = join_halves(host_wdata_in, s_q.wr_stage, bus_hi);
  assign rd_first = host_rd_in && !s_q.rd_pend;
  assign rd_same  = host_rd_in && s_q.rd_pend && (s_q.rd_hi == bus_hi);
  assign rd_pair  = host_rd_in && s_q.rd_pend && (s_q.rd_hi != bus_hi);

  // ****************************************
  // Host and network outputs
  // ****************************************
  // Only the first read of a pair reaches the register or FIFO
  assign int_rd_req_out  = rd_first;
  assign int_rd_addr_out = host_addr_in;
  assign host_rdata_out  = s_q.rdata;
  assign host_rvalid_out = s_q.rvalid;
  assign host_rd_bad_out = s_q.rbad;
  // Low-order word always leaves first toward the network
  assign net_first_half_out  = s_q.last[DHBP_HALF_W-1:0];
  assign net_second_half_out = s_q.last[DHBP_WORD_W-1:DHBP_HALF_W];

  // ****************************************
  // Assembly and split
  // ****************************************
  always_comb begin
    s_d          = s_q;
    s_d.rvalid   = host_rd_in;
    s_d.rbad     = rd_same;
    buf_in_valid = wr_pair;
    buf_in_data  = {host_addr_in, wr_word};
    if (wr_first) begin
      s_d.wr_pend  = 1'b1;
      s_d.wr_hi    = bus_hi;
      s_d.wr_stage = host_wdata_in;
    end
    // A same-half write drops the staged half and commits nothing
    if (wr_same) begin
      s_d.wr_pend = 1'b0;
    end
    if (wr_pair) begin
      s_d.wr_pend = 1'b0;
      s_d.last    = wr_word;
    end
    // Snapshot on the first read keeps both halves from one value
    if (rd_first) begin
      s_d.rd_pend = 1'b1;
      s_d.rd_hi   = bus_hi;
      s_d.rd_snap = int_rd_data_in;
      s_d.rdata   = pick_half(int_rd_data_in, bus_hi);
    end
    // Bad read returns zero and frees tracking for a fresh pair
    if (rd_same) begin
      s_d.rd_pend = 1'b0;
      s_d.rdata   = '0;
    end
    if (rd_pair) begin
      s_d.rd_pend = 1'b0;
      s_d.rdata   = pick_half(s_q.rd_snap, bus_hi);
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Commit buffer
  // ****************************************
  // Two entries ride out a receiver stall without losing a word
  dhbp_skid_buf #(
    .WIDTH (ADDR_W + DHBP_WORD_W),
    .DEPTH (DHBP_BUF_DEPTH)
  ) dhbp_skid_buf_i (
    .clk_in        (clk_in),
    .resetn_in     (resetn_in),
    .in_valid_in   (buf_in_valid),
    .in_ready_out  (buf_in_ready),
    .in_data_in    (buf_in_data),
    .out_valid_out (int_wr_valid_out),
    .out_ready_in  (int_wr_ready_in),
    .out_data_out  (buf_out_data)
  );

  assign int_wr_addr_out = buf_out_data[ADDR_W+DHBP_WORD_W-1:DHBP_WORD_W];
  assign int_wr_data_out = buf_out_data[DHBP_WORD_W-1:0];
endmodule
`default_nettype wire

// [dv/dhbp_props.sv]
// Checker for the host port pairing and buffer behaviour
`timescale 1ns/1ps
`default_nettype none
module dhbp_props
  import dhbp_pkg::*;
(
  input wire logic        clk_in, resetn_in, host_wr_in, host_rd_in, half_select_line_in,
  input wire logic        host_rvalid_out, host_rd_bad_out, host_wr_stall_out,
  input wire logic        int_wr_valid_out, int_wr_ready_in, int_rd_req_out,
  input wire logic [31:0] word_order_in, int_wr_data_out,
  input wire logic [15:0] host_wdata_in, host_rdata_out, net_first_half_out,
  input wire logic [15:0] net_second_half_out
);
  // ***
  // Pending write half tracker
  // ***
  logic        pend_q, psel_q, take;
  logic [15:0] pdat_q, low_w, high_w;
  assign take = host_wr_in && !host_wr_stall_out;
  assign low_w = (half_select_line_in ^ (word_order_in == DHBP_SWAP_VALUE)) ? pdat_q
               : host_wdata_in;
  assign high_w = (half_select_line_in ^ (word_order_in == DHBP_SWAP_VALUE)) ? host_wdata_in
                : pdat_q;
  always_ff @(posedge clk_in) begin
    if (!resetn_in) pend_q <= 1'b0;
    else if (take) pend_q <= !pend_q;
    if (take) psel_q <= half_select_line_in;
    if (take) pdat_q <= host_wdata_in;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  a_read_answer: assert property (host_rd_in |=> host_rvalid_out)
    else $error("read not answered");
  a_no_idle_ans: assert property (!host_rd_in |=> !host_rvalid_out)
    else $error("answer without read");
  a_bad_is_zero: assert property (host_rd_bad_out |-> host_rvalid_out && !host_rdata_out)
    else $error("bad read not zero");
  a_one_fetch: assert property (int_rd_req_out ##1 host_rd_in && half_select_line_in !=
    $past(half_select_line_in) |-> !int_rd_req_out) else $error("second half fetched");
  a_same_half_bad: assert property (int_rd_req_out ##1 host_rd_in && half_select_line_in ==
    $past(half_select_line_in) |=> host_rd_bad_out) else $error("same half not flagged");
  a_fresh_after: assert property (host_rd_bad_out && host_rd_in |-> int_rd_req_out)
    else $error("no fresh pair");
  a_pair_commit: assert property (take && pend_q && half_select_line_in != psel_q
    |=> int_wr_valid_out) else $error("pair not committed");
  a_same_discard: assert property (take && pend_q && half_select_line_in == psel_q
    && !int_wr_valid_out |=> !int_wr_valid_out) else $error("same half committed");
  a_low_first: assert property (take && pend_q && half_select_line_in != psel_q
    |=> net_first_half_out == $past(low_w)) else $error("network low word wrong");
  a_high_second: assert property (take && pend_q && half_select_line_in != psel_q
    |=> net_second_half_out == $past(high_w)) else $error("network high word wrong");
  a_valid_held: assert property (int_wr_valid_out && !int_wr_ready_in
    |=> int_wr_valid_out && $stable(int_wr_data_out)) else $error("stalled word dropped");
  c_pair: cover property (take && pend_q && half_select_line_in != psel_q);
  c_bad: cover property (host_rd_bad_out);
  c_stall: cover property (host_wr_stall_out && host_wr_in);
  c_swap: cover property (host_rvalid_out && word_order_in == DHBP_SWAP_VALUE);
endmodule
bind dhbp_port dhbp_props dhbp_props_i (.clk_in, .resetn_in, .host_wr_in, .host_rd_in,
  .half_select_line_in, .host_rvalid_out, .host_rd_bad_out, .host_wr_stall_out,
  .int_wr_valid_out, .int_wr_ready_in, .int_rd_req_out, .word_order_in, .int_wr_data_out,
  .host_wdata_in, .host_rdata_out, .net_first_half_out, .net_second_half_out);
`default_nettype wire

// [dv/dhbp_host_model.sv]
// Host processor model issuing 16-bit halves
`timescale 1ns/1ps
`default_nettype none
module dhbp_host_model (
  input wire logic    clk_in, stall_in,
  output logic        wr_out, rd_out, sel_out,
  output logic [7:0]  addr_out,
  output logic [15:0] data_out
);
  initial {wr_out, rd_out, sel_out, addr_out, data_out} = '0;
  // Strobes held until the taking edge; a stalled write waits
  task automatic half(input logic w, input logic [7:0] a, input logic s, input logic [15:0] d);
    wr_out <= w;
    rd_out <= !w;
    addr_out <= a;
    sel_out <= s;
    data_out <= d;
    @(negedge clk_in);
    while (w && stall_in) @(negedge clk_in);
    @(posedge clk_in);
  endtask
  // Released bus must not keep its last value
  task automatic idle();
    wr_out <= 1'b0;
    rd_out <= 1'b0;
    data_out <= ~data_out;
    @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// [dv/dhbp_port_tb.sv]
// Testbench: random paired host traffic against a queue model
`timescale 1ns/1ps
`default_nettype none
module dhbp_port_tb;
  import dhbp_pkg::*;
  logic        clk_in = 0, resetn_in = 0, rdy = 0, hold = 0, pw = 0, pr = 0, ps, rs, s;
  logic        wr, rd, sel, rvalid, bad, stall, wvalid;
  logic [7:0]  addr, waddr, raddr, a;
  logic [15:0] wd, rdata, pdat;
  logic [31:0] wo = 0, wdata, snap, r;
  logic [31:0] wos [4] = '{32'h00000000, 32'hFFFFFFFE, 32'hFFFFFFFF, 32'h0FFFFFFF};
  logic [16:0] rq [$];
  logic [39:0] wq [$];
  int          seed = 32'h3AFF, n_mismatch = 0, check_count = 0;
  always #50 clk_in = ~clk_in;
  function automatic logic [31:0] fw(input logic [7:0] x);
    return {~x, x, x ^ 8'h5A, x ^ 8'hC3};
  endfunction
  dhbp_port dhbp_port_i (.clk_in, .resetn_in, .word_order_in(wo), .host_wr_in(wr),
    .host_rd_in(rd), .host_addr_in(addr), .half_select_line_in(sel), .host_wdata_in(wd),
    .host_rdata_out(rdata), .host_rvalid_out(rvalid), .host_rd_bad_out(bad),
    .host_wr_stall_out(stall), .int_wr_valid_out(wvalid), .int_wr_ready_in(rdy),
    .int_wr_addr_out(waddr), .int_wr_data_out(wdata), .int_rd_req_out(),
    .int_rd_addr_out(raddr), .int_rd_data_in(fw(raddr)), .net_first_half_out(),
    .net_second_half_out());
  dhbp_host_model dhbp_host_model_i (.clk_in, .stall_in(stall), .wr_out(wr), .rd_out(rd),
    .sel_out(sel), .addr_out(addr), .data_out(wd));
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (!ok) begin
      n_mismatch++;
      $display("Error %0t: %s", $time, m);
    end
  endtask
  task automatic results();
    if (n_mismatch == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk_in) rdy <= !hold && $random(seed) % 4 != 0;
  // Model sees each request before its taking edge
  always @(negedge clk_in) if (resetn_in) begin
    if (rvalid) chk({bad, rdata} === rq.pop_front(), "read half");
    if (wvalid && rdy) chk({waddr, wdata} === wq.pop_front(), "word");
    if (wr && !stall && pw && sel != ps)
      wq.push_back({addr, (sel ^ (wo === DHBP_SWAP_VALUE)) ? {wd, pdat} : {pdat, wd}});
    if (wr && !stall) pdat = wd;
    if (wr && !stall) ps = sel;
    if (wr && !stall) pw = !pw;
    if (rd && !pr) snap = fw(addr);
    if (rd && pr && sel == rs) rq.push_back(17'h10000);
    else if (rd) rq.push_back({1'b0, (sel ^ (wo === DHBP_SWAP_VALUE)) ? snap[31:16] : snap[15:0]});
    if (rd) rs = sel;
    if (rd) pr = !pr;
  end
  initial begin
    #500000;
    n_mismatch++;
    results();
  end
  initial begin
    repeat (2) @(posedge clk_in);
    resetn_in <= 1;
    @(posedge clk_in);
    for (int i = 0; i < 400; i++) begin
      r = $random(seed);
      a = r[15:8];
      s = r[0];
      if (i % 100 == 0) begin
        // Stalled burst per word order so the buffer fills and refuses
        wo <= wos[i / 100];
        hold <= 1;
        fork begin repeat (12) @(posedge clk_in); hold <= 0; end join_none
        for (int j = 0; j < 3; j++) begin
          dhbp_host_model_i.half(1, 8'(a + j), 1'b0, r[15:0]);
          dhbp_host_model_i.half(1, 8'(a + j), 1'b1, r[31:16]);
        end
      end
      dhbp_host_model_i.half(!r[1], a, s, r[31:16]);
      dhbp_host_model_i.half(!r[1], a, s ^ (r[3:2] != 2'h3), r[23:8]);
      if (r[4]) dhbp_host_model_i.idle();
    end
    dhbp_host_model_i.idle();
    repeat (20) @(posedge clk_in);
    chk(wq.size() == 0 && rq.size() == 0, "words left over");
    results();
  end
endmodule
`default_nettype wire
